//--- inc/an_np_pkg.sv
package an_np_pkg;
  // register offsets (word index on the management port)
  localparam logic [4:0] ADDR_EXPANSION = 5'h06;
  localparam logic [4:0] ADDR_LOCAL_NP = 5'h07;
  localparam logic [4:0] ADDR_PARTNER_NP = 5'h08;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h10;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h11;
  // reset values
  localparam logic [15:0] EXPANSION_RESET = 16'h0004;
  localparam logic [15:0] LOCAL_NP_RESET = 16'h2001;
  localparam logic [15:0] PARTNER_NP_RESET = 16'h0000;
  // expansion field positions
  localparam int EXP_PD_FAULT = 4;
  localparam int EXP_LP_NP_ABLE = 3;
  localparam int EXP_LOCAL_NP_ABLE = 2;
  localparam int EXP_PAGE_RX = 1;
  localparam int EXP_LP_AN_ABLE = 0;
  // next page field positions
  localparam int NP_NEXT = 15;
  localparam int NP_ACK = 14;
  localparam int NP_MSG = 13;
  localparam int NP_ACK2 = 12;
  localparam int NP_TOGGLE = 11;
  localparam int NP_CODE_MSB = 10;
  // writable bits of the local next page: 15, 13, 12, 10..0
  localparam logic [15:0] LOCAL_NP_WMASK = 16'hB7FF;
  // interrupt bits
  localparam int IRQ_PAGE_RX = 0;
  localparam int IRQ_PD_FAULT = 1;
  localparam int IRQ_LP_NP = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
endpackage

//--- inc/an_flag_if.sv
`timescale 1ns/1ps
interface an_flag_if;
  logic set;
  logic clr;
  logic flag;
  modport owner (input set, input clr, output flag);
  modport user (output set, output clr, input flag);
endinterface

//--- core/sticky_flag.sv
`timescale 1ns/1ps
module sticky_flag (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // flag control
  an_flag_if.owner f
);
  typedef struct packed {
    logic flag;
  } flag_state_t;

  flag_state_t st_q;
  flag_state_t st_d;

  // set wins over clear so an event in the clearing cycle is kept
  always_comb begin
    st_d = st_q;
    if (f.clr) begin
      st_d.flag = 1'b0;
    end
    if (f.set) begin
      st_d.flag = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign f.flag = st_q.flag;

  set_wins_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    f.set |=> f.flag) else $error("flag lost its set");
endmodule

//--- core/autoneg_next_page_regs.sv
`timescale 1ns/1ps
// How it works
// - bit 4 latches parallel detection fault
// - bit 3 shows partner next page ability
// - bit 2 local next page able, reads one
// - bit 1 latches new page received
// - bit 0 shows partner autoneg ability
// - bit 15 writable, sent as next page
// - bit 13 message page, writable, resets one
// - bit 12 writable, sent as acknowledge 2
// - toggle is inverse of previous toggle
// - code field writable, resets to 1
// - partner page fields captured read-only
// - partner code field captured read-only
// - partner resets zero, expansion resets 4
module autoneg_next_page_regs (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // negotiation core status
  input wire logic i_pd_fault,
  input wire logic i_lp_np_able,
  input wire logic i_lp_an_able,
  // page exchange with the arbiter
  input wire logic i_page_rx,
  input wire logic [15:0] i_rx_page,
  input wire logic i_np_sent,
  output logic [15:0] o_tx_page,
  // interrupt
  output logic o_irq
);
  typedef struct packed {
    logic [15:0] local_np;
    logic [15:0] partner_np;
    logic last_toggle;
    logic [2:0] irq_mask;
    logic [2:0] lp_np_prev;
    logic [15:0] rdata;
  } reg_state_t;

  reg_state_t st_q;
  reg_state_t st_d;

  an_flag_if pd_if ();
  an_flag_if pr_if ();
  an_flag_if irq_if [3] ();

  logic exp_read;
  logic [15:0] expansion;
  logic [2:0] irq_status;
  logic [2:0] irq_evt;

  assign exp_read = i_rd && (i_addr == an_np_pkg::ADDR_EXPANSION);

  // latched until software reads the expansion word
  assign pd_if.set = i_pd_fault;
  assign pd_if.clr = exp_read;
  assign pr_if.set = i_page_rx;
  assign pr_if.clr = exp_read;

  sticky_flag u_pd_flag (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .f(pd_if)
  );

  sticky_flag u_pr_flag (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .f(pr_if)
  );

  assign irq_evt[an_np_pkg::IRQ_PAGE_RX] = i_page_rx;
  assign irq_evt[an_np_pkg::IRQ_PD_FAULT] = i_pd_fault;
  assign irq_evt[an_np_pkg::IRQ_LP_NP] = i_lp_np_able && !st_q.lp_np_prev[0];

  // interrupt status is separate so reading expansion does not drop the irq
  for (genvar g = 0; g < 3; g++) begin : g_irq
    assign irq_if[g].set = irq_evt[g];
    assign irq_if[g].clr = i_wr && (i_addr == an_np_pkg::ADDR_IRQ_STATUS) && i_wdata[g];
    assign irq_status[g] = irq_if[g].flag;
    sticky_flag u_irq_flag (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .f(irq_if[g])
    );
  end

  always_comb begin
    expansion = 16'h0000;
    expansion[an_np_pkg::EXP_PD_FAULT] = pd_if.flag;
    expansion[an_np_pkg::EXP_LP_NP_ABLE] = i_lp_np_able;
    expansion[an_np_pkg::EXP_LOCAL_NP_ABLE] = an_np_pkg::EXPANSION_RESET[2];
    expansion[an_np_pkg::EXP_PAGE_RX] = pr_if.flag;
    expansion[an_np_pkg::EXP_LP_AN_ABLE] = i_lp_an_able;
  end

  always_comb begin
    st_d = st_q;
    st_d.lp_np_prev = {2'h0, i_lp_np_able};
    if (i_wr && (i_addr == an_np_pkg::ADDR_LOCAL_NP)) begin
      // reserved 14 and toggle 11 are not stored from the bus
      st_d.local_np = i_wdata & an_np_pkg::LOCAL_NP_WMASK;
    end
    if (i_wr && (i_addr == an_np_pkg::ADDR_IRQ_MASK)) begin
      st_d.irq_mask = i_wdata[2:0];
    end
    if (i_np_sent) begin
      st_d.last_toggle = o_tx_page[an_np_pkg::NP_TOGGLE];
    end
    if (i_page_rx) begin
      st_d.partner_np = i_rx_page;
    end
    st_d.rdata = 16'h0000;
    if (i_rd) begin
      case (i_addr)
        an_np_pkg::ADDR_EXPANSION: st_d.rdata = expansion;
        an_np_pkg::ADDR_LOCAL_NP: begin
          st_d.rdata = st_q.local_np;
          st_d.rdata[an_np_pkg::NP_TOGGLE] = !st_q.last_toggle;
        end
        an_np_pkg::ADDR_PARTNER_NP: st_d.rdata = st_q.partner_np;
        an_np_pkg::ADDR_IRQ_STATUS: st_d.rdata = {13'h0000, irq_status};
        an_np_pkg::ADDR_IRQ_MASK: st_d.rdata = {13'h0000, st_q.irq_mask};
        default: st_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_q.local_np <= an_np_pkg::LOCAL_NP_RESET;
      st_q.partner_np <= an_np_pkg::PARTNER_NP_RESET;
      st_q.last_toggle <= 1'b1;
      st_q.irq_mask <= an_np_pkg::IRQ_RESET;
      st_q.lp_np_prev <= 3'h0;
      st_q.rdata <= 16'h0000;
    end else begin
      st_q <= st_d;
    end
  end

  // transmitted page: software fields, ack left to the arbiter, fresh toggle
  always_comb begin
    o_tx_page = st_q.local_np;
    o_tx_page[an_np_pkg::NP_ACK] = 1'b0;
    o_tx_page[an_np_pkg::NP_TOGGLE] = !st_q.last_toggle;
  end

  assign o_rdata = st_q.rdata;
  assign o_irq = |(irq_status & st_q.irq_mask);

  pd_latch_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_pd_fault && !exp_read |=> pd_if.flag) else $error("fault not latched");
  lp_np_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    exp_read |=> o_rdata[3] == $past(i_lp_np_able)) else $error("np able wrong");
  local_able_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    exp_read |=> o_rdata[2]) else $error("local able not one");
  page_latch_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_page_rx ##1 exp_read |=> o_rdata[1]) else $error("page rx lost");
  an_able_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    exp_read |=> o_rdata[0] == $past(i_lp_an_able)) else $error("an able wrong");
  np_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_wr && i_addr == an_np_pkg::ADDR_LOCAL_NP |=>
      o_tx_page[15] == $past(i_wdata[15]) && o_tx_page[13] == $past(i_wdata[13]) &&
      o_tx_page[12] == $past(i_wdata[12]) && o_tx_page[10:0] == $past(i_wdata[10:0]))
    else $error("tx page not written");
  toggle_flip_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_np_sent |=> o_tx_page[11] != $past(o_tx_page[11])) else $error("toggle stuck");
  rx_capture_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_page_rx ##1 (i_rd && i_addr == an_np_pkg::ADDR_PARTNER_NP && !i_page_rx) |=>
      o_rdata == $past(i_rx_page, 2)) else $error("partner page wrong");
  rd_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    exp_read && !i_page_rx |=> !pr_if.flag) else $error("page flag not cleared");
  reserved_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    exp_read |=> o_rdata[15:5] == 11'h000) else $error("reserved bits set");
endmodule

//--- sim/link_partner_model.sv
`timescale 1ns/1ps
module link_partner_model (
  // clock
  input wire logic i_sys_clk,
  // command from the bench
  input wire logic i_go,
  input wire logic [15:0] i_word,
  // toward the device
  output logic o_page_rx,
  output logic [15:0] o_rx_page
);
  initial begin
    o_page_rx = 1'b0;
    o_rx_page = 16'h0000;
  end
  // word is only valid with the strobe; scrambled otherwise so no stale capture passes
  always @(posedge i_sys_clk) begin
    o_page_rx <= i_go;
    o_rx_page <= i_go ? i_word : ~o_rx_page;
  end
endmodule

//--- sim/tb_autoneg_next_page_regs.sv
`timescale 1ns/1ps
module tb_autoneg_next_page_regs;
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [4:0] i_addr = 5'h00;
  logic [15:0] i_wdata = 16'h0000, o_rdata, o_tx_page, rx_page, lp_word = 16'h0000;
  logic i_pd_fault = 1'b0, i_lp_np_able = 1'b0, i_lp_an_able = 1'b0;
  logic i_np_sent = 1'b0, lp_go = 1'b0, page_rx, o_irq;
  int fail_count = 0, samples_checked = 0;
  initial forever #12.5 i_sys_clk = ~i_sys_clk;
  link_partner_model lp (.i_sys_clk(i_sys_clk), .i_go(lp_go), .i_word(lp_word),
    .o_page_rx(page_rx), .o_rx_page(rx_page));
  autoneg_next_page_regs dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pd_fault(i_pd_fault), .i_lp_np_able(i_lp_np_able), .i_lp_an_able(i_lp_an_able),
    .i_page_rx(page_rx), .i_rx_page(rx_page), .i_np_sent(i_np_sent),
    .o_tx_page(o_tx_page), .o_irq(o_irq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  // which: 0 page sent, 1 partner page, 2 detection fault
  task automatic pulse(input int which);
    @(posedge i_sys_clk);
    if (which == 0) begin
      i_np_sent <= 1'b1;
    end else if (which == 1) begin
      lp_go <= 1'b1;
    end else begin
      i_pd_fault <= 1'b1;
    end
    @(posedge i_sys_clk);
    i_np_sent <= 1'b0;
    lp_go <= 1'b0;
    i_pd_fault <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
  endtask
  task automatic t_reset;
    rd(an_np_pkg::ADDR_EXPANSION, 16'h0004);
    rd(an_np_pkg::ADDR_LOCAL_NP, 16'h2001);
    rd(an_np_pkg::ADDR_PARTNER_NP, 16'h0000);
    rd(5'h1F, 16'h0000);
    chk({15'h0000, o_irq}, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_local;
    wr(an_np_pkg::ADDR_LOCAL_NP, 16'hFFFF);
    wr(an_np_pkg::ADDR_EXPANSION, 16'hFFFF);
    rd(an_np_pkg::ADDR_EXPANSION, 16'h0004);
    rd(an_np_pkg::ADDR_LOCAL_NP, 16'hB7FF);
    chk(o_tx_page, 16'hB7FF);
    pulse(0);
    chk(o_tx_page, 16'hBFFF);
    pulse(0);
    chk(o_tx_page, 16'hB7FF);
    wr(an_np_pkg::ADDR_LOCAL_NP, 16'h0000);
    #1 chk(o_tx_page, 16'h0000);
    $display("test local page done");
  endtask
  task automatic t_page;
    wr(an_np_pkg::ADDR_IRQ_MASK, 16'h0001);
    lp_word <= 16'hDABC;
    pulse(1);
    rd(an_np_pkg::ADDR_PARTNER_NP, 16'hDABC);
    chk({15'h0000, o_irq}, 16'h0001);
    rd(an_np_pkg::ADDR_EXPANSION, 16'h0006);
    rd(an_np_pkg::ADDR_EXPANSION, 16'h0004);
    wr(an_np_pkg::ADDR_IRQ_STATUS, 16'h0001);
    #1 chk({15'h0000, o_irq}, 16'h0000);
    lp_word <= 16'h0123;
    pulse(1);
    rd(an_np_pkg::ADDR_PARTNER_NP, 16'h0123);
    $display("test partner page done");
  endtask
  task automatic t_status;
    i_lp_np_able <= 1'b1;
    i_lp_an_able <= 1'b1;
    wr(an_np_pkg::ADDR_IRQ_STATUS, 16'h0001);
    pulse(2);
    chk({15'h0000, o_irq}, 16'h0000);
    rd(an_np_pkg::ADDR_IRQ_STATUS, 16'h0006);
    wr(an_np_pkg::ADDR_IRQ_MASK, 16'h0002);
    #1 chk({15'h0000, o_irq}, 16'h0001);
    rd(an_np_pkg::ADDR_EXPANSION, 16'h001F);
    rd(an_np_pkg::ADDR_EXPANSION, 16'h000D);
    i_lp_np_able <= 1'b0;
    i_lp_an_able <= 1'b0;
    wr(an_np_pkg::ADDR_IRQ_STATUS, 16'h0007);
    rd(an_np_pkg::ADDR_EXPANSION, 16'h0004);
    chk({15'h0000, o_irq}, 16'h0000);
    $display("test status done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // generous: the sequence needs well under a thousand cycles
  initial begin
    #(25 * 5000);
    fail_count++;
    results();
  end
  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_local();
    t_page();
    t_status();
    results();
  end
endmodule
